//--- verilog/sio_mapper.sv
`default_nettype none
// Overview of operation
// R1 - A too short restart or acknowledge pulse raises the mapping fault.
// R2 - A restart or acknowledge pulse held over 30 s raises the same fault.
// R3 - The AND of the five selection inputs resets the door flip-flop.
// R4 - Door request and not all selections set the door-lock request flop.
// R5 - A safe AND gives its safe input AND up to three functional inputs.
// R6 - An unconnected optional input of a safe AND counts as true.
// R7 - A safe AND result may drive mode, enabling, special, brake or door.
// R8 - Sixteen safe AND instances work side by side.
// R9 - The functional connector copies its input to the homing reference output.
// R10 - Each weighted e-stop input leaves the AND while its bypass is high.
// R11 - A zero AND drops the lockout until a restart falling edge follows.
// R12 - Acknowledge wired: its fall precedes restart's, with AND held high.
// R13 - A wired final safe input is ANDed with the lockout output.
// R14 - The e-stop result drives only bit 1 of the control word.
// R15 - Edges compare with the last sample; pulse lengths count cycles.
module sio_mapper
   import sio_pkg::*;
#(
   parameter logic [31:0] MAX_PULSE_CYCLES = MAX_PULSE_CYC
)(
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   output logic      [31:0]          reg_rdata,
   input  wire logic                 door_request,
   input  wire logic [N_SEL-1:0]     safe_select,
   input  wire logic [4*N_AND-1:0]   and_inputs,
   input  wire logic                 homing_input,
   input  wire logic                 primary_safe_weighted_input,
   input  wire logic [N_W-1:1]       weighted_inputs,
   input  wire logic                 primary_input_mask,
   input  wire logic [N_W-1:1]       input_masks,
   input  wire logic                 restart_input,
   input  wire logic                 ack_input,
   input  wire logic                 final_safe_input,
   output logic [CW_SMM0+N_AND-1:0]  state_control_word,
   output logic                      brake_release,
   output logic                      door_unlock_request,
   output logic                      homing_reference,
   output logic                      door_lock_supervision,
   output logic                      input_mapping_fault,
   output logic                      irq
);
   localparam int NPIN = 1 + N_SEL + 4*N_AND + 1 + 2*N_W + 3;

   logic [NPIN-1:0]   pin_meta_reg;
   logic [NPIN-1:0]   pin_reg;
   // software-visible configuration and status
   logic [1:0]        ctrl_reg;
   logic [31:0]       min_pulse_reg;
   logic [31:0]       and_conn_reg;
   logic [31:0]       route_lo_reg;
   logic [31:0]       route_hi_reg;
   logic [3:0]        status_reg;
   logic [3:0]        mask_reg;
   logic [3:0]        status_set;
   logic              door_ff_reg;
   logic              estop_out_reg;
   logic              released;
   sio_lock_e         lock_state;
   // synchronised copies of the pins
   logic              s_door;
   logic [N_SEL-1:0]  s_sel;
   logic [4*N_AND-1:0] s_and;
   logic              s_home;
   logic [N_W-1:0]    s_w;
   logic [N_W-1:0]    s_m;
   logic              s_restart;
   logic              s_ack;
   logic              s_final;
   // combinational results between the stages
   logic [N_AND-1:0]  and_res;
   logic [63:0]       route;
   logic              masked_and;
   logic              all_sel;
   logic [1:0]        short_hit;
   logic [1:0]        long_hit;
   logic              estop_next;

   // two flops on every pin before any logic looks at it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_reg <= '0;
         pin_reg      <= '0;
      end else begin
         pin_meta_reg <= {door_request, safe_select, and_inputs,
                          homing_input, weighted_inputs,
                          primary_safe_weighted_input, input_masks,
                          primary_input_mask, restart_input, ack_input,
                          final_safe_input};
         pin_reg      <= pin_meta_reg;
      end
   end

   assign {s_door, s_sel, s_and, s_home, s_w, s_m,
           s_restart, s_ack, s_final} = pin_reg;

   // safe AND of one instance; unused optional inputs read as true
   function automatic logic and_of(input logic [3:0] in,
                                   input logic       c3,
                                   input logic       c4);
      and_of = in[0] & in[1] & (in[2] | ~c3) & (in[3] | ~c4); // R5 R6
   endfunction : and_of

   // AND of all instances routed to one target; no source reads false
   function automatic logic routed(input logic [N_AND-1:0] res,
                                   input logic [63:0]      rt,
                                   input logic [3:0]       code);
      logic any;
      logic acc;
      any = 1'b0;
      acc = 1'b1;
      for (int i = 0; i < N_AND; i++) begin
         if (rt[4*i +: 4] == code) begin
            any = 1'b1;
            acc = acc & res[i];
         end
      end
      routed = any & acc;
   endfunction : routed

   // sixteen independent safe AND instances
   always_comb begin
      for (int i = 0; i < N_AND; i++) begin
         and_res[i] = and_of(s_and[4*i +: 4], and_conn_reg[i],
                             and_conn_reg[16+i]); // R8
      end
   end

   assign route = {route_hi_reg, route_lo_reg};

   // bypassed inputs drop out of the AND; all bypassed reads true
   assign masked_and = &(s_w | s_m); // R10
   assign all_sel    = &s_sel;

   sio_lockout u_lockout (
      .clk      (clk),
      .reset_n  (reset_n),
      .and_ok   (masked_and),
      .restart  (s_restart),
      .ack      (s_ack),
      .ack_conn (ctrl_reg[CTRL_ACK_CONN]),
      .released (released),
      .state    (lock_state)
   );

   // restart and acknowledge pulse supervision
   sio_pulse_mon u_mon_start (
      .clk        (clk),
      .reset_n    (reset_n),
      .level      (s_restart),
      .min_cycles (min_pulse_reg),
      .max_cycles (MAX_PULSE_CYCLES),
      .too_short  (short_hit[0]),
      .too_long   (long_hit[0])
   );

   sio_pulse_mon u_mon_ack (
      .clk        (clk),
      .reset_n    (reset_n),
      .level      (s_ack),
      .min_cycles (min_pulse_reg),
      .max_cycles (MAX_PULSE_CYCLES),
      .too_short  (short_hit[1]),
      .too_long   (long_hit[1])
   );

   // final safe input gates the lockout only when wired
   assign estop_next = released &
                       (s_final | ~ctrl_reg[CTRL_FINAL_CONN]); // R13

   // door request flip-flop; reset dominates set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         door_ff_reg <= 1'b0;
      end else if (all_sel) begin
         door_ff_reg <= 1'b0; // R3
      end else if (s_door) begin
         door_ff_reg <= 1'b1; // R4
      end
   end

   // registered outputs so no pin sees a decode glitch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         estop_out_reg         <= 1'b0;
         state_control_word    <= '0;
         brake_release         <= 1'b0;
         door_unlock_request   <= 1'b0;
         homing_reference      <= 1'b0;
         door_lock_supervision <= 1'b0;
      end else begin
         estop_out_reg <= estop_next;
         state_control_word[CW_MODE]   <= routed(and_res, route, RT_MODE);
         state_control_word[CW_ESTOP]  <= estop_next; // R14
         state_control_word[CW_ENABLE] <= routed(and_res, route,
                                                 RT_ENABLE); // R7
         for (int i = 0; i < N_AND; i++) begin
            state_control_word[CW_SMM0+i] <=
               (route[4*i +: 4] == RT_SMM) & and_res[i]; // R7
         end
         brake_release         <= routed(and_res, route, RT_BRAKE);
         door_unlock_request   <= routed(and_res, route, RT_DOOR);
         homing_reference      <= s_home; // R9
         door_lock_supervision <= door_ff_reg; // R4
      end
   end

   // events that land in the sticky status
   assign status_set[ST_SHORT]   = |short_hit; // R1
   assign status_set[ST_LONG]    = |long_hit; // R2
   assign status_set[ST_TRIP]    = estop_out_reg & ~estop_next;
   assign status_set[ST_RELEASE] = ~estop_out_reg & estop_next;

   // configuration registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg      <= RST_CTRL;
         min_pulse_reg <= RST_MIN_PULSE;
         and_conn_reg  <= RST_AND_CONN;
         route_lo_reg  <= RST_ROUTE;
         route_hi_reg  <= RST_ROUTE;
         mask_reg      <= RST_MASK;
      end else if (reg_write) begin
         case (reg_addr)
            OFS_CTRL:      ctrl_reg      <= reg_wdata[1:0];
            OFS_MIN_PULSE: min_pulse_reg <= reg_wdata;
            OFS_AND_CONN:  and_conn_reg  <= reg_wdata;
            OFS_ROUTE_LO:  route_lo_reg  <= reg_wdata;
            OFS_ROUTE_HI:  route_hi_reg  <= reg_wdata;
            OFS_MASK:      mask_reg      <= reg_wdata[3:0];
            default:       ;
         endcase
      end
   end

   // write one to clear; a new event in the same cycle still sticks
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= 4'h0;
      end else begin
         status_reg <= (status_reg &
                        ~((reg_write && reg_addr == OFS_STATUS) ?
                          reg_wdata[3:0] : 4'h0)) | status_set;
      end
   end

   // fault stays up until software clears it
   assign input_mapping_fault = status_reg[ST_SHORT] | status_reg[ST_LONG];
   assign irq = |(status_reg & mask_reg);

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_read) begin
         case (reg_addr)
            OFS_CTRL:      reg_rdata <= {30'h0, ctrl_reg};
            OFS_MIN_PULSE: reg_rdata <= min_pulse_reg;
            OFS_AND_CONN:  reg_rdata <= and_conn_reg;
            OFS_ROUTE_LO:  reg_rdata <= route_lo_reg;
            OFS_ROUTE_HI:  reg_rdata <= route_hi_reg;
            OFS_STATUS:    reg_rdata <= {28'h0, status_reg};
            OFS_MASK:      reg_rdata <= {28'h0, mask_reg};
            OFS_STATE:     reg_rdata <= {12'h0, and_res, 1'b0,
                                         door_ff_reg, lock_state};
            default:       reg_rdata <= 32'h0;
         endcase
      end
   end

   // checks on this block's own logic, one clock domain throughout
   AST_DOOR_RESET: assert property (@(posedge clk) disable iff (!reset_n)
      all_sel |=> !door_ff_reg) // R3
      else $error("door flip-flop not reset by full selection");
   AST_DOOR_SET: assert property (@(posedge clk) disable iff (!reset_n)
      s_door && !all_sel |=> ##1 door_lock_supervision) // R4
      else $error("door request did not reach door-lock request");
   AST_HOMING: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 homing_reference == $past(s_home)) // R9
      else $error("homing reference differs from its input");
   AST_ESTOP_BIT: assert property (@(posedge clk) disable iff (!reset_n)
      state_control_word[CW_ESTOP] |-> $past(released)) // R14
      else $error("e-stop bit high without a released lockout");
   AST_MODE_ROUTE: assert property (@(posedge clk) disable iff (!reset_n)
      $past(route_lo_reg[3:0]) == RT_MODE && !$past(and_res[0]) |->
      !state_control_word[CW_MODE]) // R7
      else $error("mode bit high although a routed instance is false");
   AST_BYPASS: assert property (@(posedge clk) disable iff (!reset_n)
      (&s_m) |-> masked_and) // R10
      else $error("fully bypassed AND reads false");
   AST_FINAL: assert property (@(posedge clk) disable iff (!reset_n)
      ctrl_reg[CTRL_FINAL_CONN] && !s_final |=> !estop_out_reg) // R13
      else $error("final safe input low but e-stop output high");
   AST_FAULT: assert property (@(posedge clk) disable iff (!reset_n)
      (|short_hit) || (|long_hit) |=> input_mapping_fault) // R1
      else $error("pulse fault not raised");
endmodule : sio_mapper
`default_nettype wire

//--- inc/sio_pkg.sv
`default_nettype none
package sio_pkg;
   // clock and pulse supervision timing
   localparam int          CLK_HZ        = 50_000_000;
   localparam int          MAX_PULSE_S   = 30;
   localparam logic [31:0] MAX_PULSE_CYC =
      32'(longint'(MAX_PULSE_S) * longint'(CLK_HZ));

   // block sizes
   localparam int N_AND = 16;
   localparam int N_SEL = 5;
   localparam int N_W   = 4;

   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_MIN_PULSE = 8'h04;
   localparam logic [7:0] OFS_AND_CONN  = 8'h08;
   localparam logic [7:0] OFS_ROUTE_LO  = 8'h0c;
   localparam logic [7:0] OFS_ROUTE_HI  = 8'h10;
   localparam logic [7:0] OFS_STATUS    = 8'h14;
   localparam logic [7:0] OFS_MASK      = 8'h18;
   localparam logic [7:0] OFS_STATE     = 8'h1c;

   // reset values
   localparam logic [1:0]  RST_CTRL      = 2'h0;
   localparam logic [31:0] RST_MIN_PULSE = 32'h0000_0001;
   localparam logic [31:0] RST_AND_CONN  = 32'h0000_0000;
   localparam logic [31:0] RST_ROUTE     = 32'h0000_0000;
   localparam logic [3:0]  RST_MASK      = 4'h0;

   // control bit positions
   localparam int CTRL_ACK_CONN   = 0;
   localparam int CTRL_FINAL_CONN = 1;

   // status bit positions
   localparam int ST_SHORT   = 0;
   localparam int ST_LONG    = 1;
   localparam int ST_TRIP    = 2;
   localparam int ST_RELEASE = 3;

   // control word bit positions
   localparam int CW_MODE   = 0;
   localparam int CW_ESTOP  = 1;
   localparam int CW_ENABLE = 2;
   localparam int CW_SMM0   = 3;

   // routing codes of a safe AND instance
   localparam logic [3:0] RT_NONE   = 4'h0;
   localparam logic [3:0] RT_MODE   = 4'h1;
   localparam logic [3:0] RT_ENABLE = 4'h2;
   localparam logic [3:0] RT_BRAKE  = 4'h3;
   localparam logic [3:0] RT_DOOR   = 4'h4;
   localparam logic [3:0] RT_SMM    = 4'h5;

   typedef enum logic [1:0] {
      SIO_WAIT_ACK,
      SIO_WAIT_START,
      SIO_RELEASED
   } sio_lock_e;
endpackage : sio_pkg
`default_nettype wire

//--- verilog/sio_pulse_mon.sv
`default_nettype none
module sio_pulse_mon
   import sio_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        level,
   input  wire logic [31:0] min_cycles,
   input  wire logic [31:0] max_cycles,
   output logic             too_short,
   output logic             too_long
);
   logic [31:0] count_reg;
   logic        level_reg;

   // count high cycles; saturates so an endless pulse flags only once
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 32'h0;
      end else if (!level) begin
         count_reg <= 32'h0;
      end else if (count_reg <= max_cycles) begin
         count_reg <= count_reg + 32'h1; // R15
      end
   end

   // previous sample for the falling edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= level;
      end
   end

   assign too_short = level_reg && !level && (count_reg < min_cycles); // R1
   assign too_long  = level && (count_reg == max_cycles); // R2

   AST_LONG_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
      too_long |=> !too_long) // R2
      else $error("long pulse flagged twice in a row");
   AST_SHORT_EDGE: assert property (@(posedge clk) disable iff (!reset_n)
      too_short |-> $past(level) && !level) // R1
      else $error("short pulse flagged without a falling edge");
endmodule : sio_pulse_mon
`default_nettype wire

//--- verilog/sio_lockout.sv
`default_nettype none
module sio_lockout
   import sio_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  reset_n,
   input  wire logic  and_ok,
   input  wire logic  restart,
   input  wire logic  ack,
   input  wire logic  ack_conn,
   output logic       released,
   output sio_lock_e  state
);
   sio_lock_e state_reg;
   sio_lock_e state_next;
   logic      restart_reg;
   logic      ack_reg;
   logic      start_fall;
   logic      ack_fall;

   // previous samples for edge detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         restart_reg <= 1'b0;
         ack_reg     <= 1'b0;
      end else begin
         restart_reg <= restart;
         ack_reg     <= ack;
      end
   end

   assign start_fall = restart_reg && !restart; // R15
   assign ack_fall   = ack_reg && !ack; // R15

   // a drop of the AND always relocks, whatever the state
   always_comb begin
      state_next = state_reg;
      if (!and_ok) begin
         state_next = ack_conn ? SIO_WAIT_ACK : SIO_WAIT_START; // R11
      end else begin
         case (state_reg)
            SIO_WAIT_ACK: begin
               // an unwired acknowledge must not leave the lock stuck here
               if (ack_fall || !ack_conn) begin
                  state_next = SIO_WAIT_START; // R12
               end
            end
            SIO_WAIT_START: begin
               if (start_fall) begin
                  state_next = SIO_RELEASED; // R11
               end
            end
            SIO_RELEASED: state_next = SIO_RELEASED;
            default:      state_next = SIO_WAIT_ACK;
         endcase
      end
   end

   // starts locked so power-up never counts as a restart
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SIO_WAIT_ACK;
      end else begin
         state_reg <= state_next;
      end
   end

   assign state    = state_reg;
   assign released = (state_reg == SIO_RELEASED);

   AST_RELOCK: assert property (@(posedge clk) disable iff (!reset_n)
      !and_ok |=> !released) // R11
      else $error("lockout stayed released after AND dropped");
   AST_RELEASE_CAUSE: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(released) |-> $past(start_fall) && $past(and_ok)) // R11
      else $error("release without start falling edge");
   AST_ACK_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(released) && ack_conn |->
      $past(state_reg) == SIO_WAIT_START) // R12
      else $error("release skipped acknowledge step");
endmodule : sio_lockout
`default_nettype wire

//--- test/sio_far_side.sv
`default_nettype none
// push buttons for restart and acknowledge, both idle low
module sio_far_side (
   input  wire logic clk,
   output logic      restart_input,
   output logic      ack_input
);
   timeunit 1ns;
   timeprecision 1ps;

   // a button rests released; the lockout acts on its release edge, the pulse monitors on how long it is held
   initial begin
      restart_input = 1'b0;
      ack_input     = 1'b0;
   end

   // hold one button for len cycles, then release and let it settle
   task automatic press(input bit sel, input int len);
      @(posedge clk);
      if (sel) begin
         ack_input <= 1'b1;
      end else begin
         restart_input <= 1'b1;
      end
      repeat (len) @(posedge clk);
      ack_input     <= 1'b0;
      restart_input <= 1'b0;
      repeat (8) @(posedge clk); // sync plus count path
      #1;
   endtask : press
endmodule : sio_far_side
`default_nettype wire

//--- test/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sio_pkg::*;

   // short long-pulse limit keeps the run brief
   localparam logic [31:0] MAXC = 32'd200;
   logic               clk, reset_n, reg_write, reg_read;
   logic [7:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata;
   logic               door_request, homing_input, w1, m1, fin;
   logic [N_SEL-1:0]   safe_select;
   logic [4*N_AND-1:0] and_inputs;
   logic [N_W-1:1]     wn, mn;
   logic               restart_input, ack_input;
   logic [18:0]        cw;
   logic               brk, dul, home, dls, fault, irq;
   int                 mismatches, samples_checked, cycles;

   sio_far_side far (.clk(clk), .restart_input(restart_input),
      .ack_input(ack_input));

   sio_mapper #(.MAX_PULSE_CYCLES(MAXC)) DUT (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .door_request(door_request),
      .safe_select(safe_select), .and_inputs(and_inputs),
      .homing_input(homing_input), .primary_safe_weighted_input(w1),
      .weighted_inputs(wn), .primary_input_mask(m1), .input_masks(mn),
      .restart_input(restart_input), .ack_input(ack_input),
      .final_safe_input(fin), .state_control_word(cw),
      .brake_release(brk), .door_unlock_request(dul),
      .homing_reference(home), .door_lock_supervision(dls),
      .input_mapping_fault(fault), .irq(irq));

   // clock, reset and every input defined from time zero
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
      {door_request, homing_input, w1, m1, fin} = '0;
      {safe_select, and_inputs, wn, mn} = '0;
   end

   // a hung wait must still end in the verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic complete_run;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr

   // read data is valid from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata & m, exp);
   endtask : rd

   // two sync flops plus up to two output stages
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask : settle

   task automatic t_reset;
      rd(OFS_CTRL, 32'hffff_ffff, 32'h0);
      rd(OFS_MIN_PULSE, 32'hffff_ffff, 32'h1);
      rd(OFS_STATE, 32'h3, 32'h1);
      rd(8'h40, 32'hffff_ffff, 32'h0);
   endtask : t_reset

   task automatic t_door;
      @(posedge clk);
      door_request <= 1'b1;
      safe_select  <= 5'h0f;
      settle();
      chk(dls, 1'b1);
      @(posedge clk);
      door_request <= 1'b0;
      settle();
      chk(dls, 1'b1);
      @(posedge clk);
      safe_select <= 5'h1f;
      settle();
      chk(dls, 1'b0);
      @(posedge clk);
      safe_select <= 5'h1e;
      settle();
      chk(dls, 1'b0);
   endtask : t_door

   // instances 0..4 routed to mode, enable, brake, door, own mode bit
   task automatic t_and;
      wr(OFS_ROUTE_LO, 32'h0005_4321);
      @(posedge clk);
      and_inputs <= {16{4'h3}};
      settle();
      chk(cw, 19'h00085);
      chk({brk, dul}, 2'b11);
      rd(OFS_STATE, 32'h000f_fff0, 32'h000f_fff0);
      wr(OFS_AND_CONN, 32'h0000_0001);
      @(posedge clk);
      and_inputs[4] <= 1'b0;
      settle();
      chk(cw, 19'h00080);
      rd(OFS_STATE, 32'h000f_fff0, 32'h000f_ffc0);
   endtask : t_and

   task automatic t_home;
      @(posedge clk);
      homing_input <= 1'b1;
      settle();
      chk(home, 1'b1);
      @(posedge clk);
      homing_input <= 1'b0;
      settle();
      chk(home, 1'b0);
   endtask : t_home

   task automatic t_estop;
      @(posedge clk);
      w1 <= 1'b1;
      wn <= 3'h7;
      settle();
      chk(cw, 19'h00080);
      far.press(0, 3);
      chk(cw, 19'h00082);
      @(posedge clk);
      wn[2] <= 1'b0;
      settle();
      chk(cw[1], 1'b0);
      @(posedge clk);
      mn[2] <= 1'b1;
      settle();
      chk(cw[1], 1'b0);
      far.press(0, 3);
      chk(cw[1], 1'b1);
      rd(OFS_STATUS, 32'hc, 32'hc);
      wr(OFS_CTRL, 32'h1);
      @(posedge clk);
      w1 <= 1'b0;
      settle();
      @(posedge clk);
      w1 <= 1'b1;
      far.press(0, 3);
      chk(cw[1], 1'b0);
      far.press(1, 3);
      far.press(0, 3);
      chk(cw[1], 1'b1);
      wr(OFS_CTRL, 32'h3);
      settle();
      chk(cw[1], 1'b0);
      @(posedge clk);
      fin <= 1'b1;
      settle();
      chk(cw[1], 1'b1);
      @(posedge clk);
      {m1, mn} <= 4'hf;
      w1       <= 1'b0;
      settle();
      chk(cw[1], 1'b1);
   endtask : t_estop

   task automatic t_pulse;
      wr(OFS_STATUS, 32'hf);
      wr(OFS_MIN_PULSE, 32'd5);
      wr(OFS_MASK, 32'h1);
      far.press(0, 2);
      rd(OFS_STATUS, 32'h3, 32'h1);
      chk({fault, irq}, 2'b11);
      wr(OFS_STATUS, 32'h1);
      settle();
      chk({fault, irq}, 2'b00);
      far.press(1, 4);
      rd(OFS_STATUS, 32'h3, 32'h1);
      wr(OFS_STATUS, 32'h1);
      far.press(0, 5);
      rd(OFS_STATUS, 32'h3, 32'h0);
      wr(OFS_MASK, 32'h0);
      far.press(0, int'(MAXC) + 20);
      rd(OFS_STATUS, 32'h2, 32'h2);
      chk({fault, irq}, 2'b10);
   endtask : t_pulse

   // main sequence
   initial begin
      mismatches      = 0;
      samples_checked = 0;
      cycles          = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_door();
      t_and();
      t_home();
      t_estop();
      t_pulse();
      complete_run();
   end
endmodule : tb
`default_nettype wire
